// ---- pkg/tll_pkg.sv ----
// constants for the temperature limit register block
// assumes one 50 MHz system clock and a two-wire slave front end
package tll_pkg;
	// ==================================================
	// bus addressing
	localparam logic [3:0] DEV_ADDR_HI = 4'h9; // fixed upper address bits 1001
	localparam logic [7:0] PTR_LOW_LIMIT = 8'h02; // low_temp_limit pointer
	localparam logic [7:0] PTR_HIGH_LIMIT = 8'h03; // high_temp_limit pointer
	localparam logic [3:0] BITS_PER_BYTE = 4'h8; // bits before the ack slot
	localparam logic [1:0] DATA_UPPER = 2'h0; // data byte index: upper
	localparam logic [1:0] DATA_LOWER = 2'h1; // data byte index: lower
	localparam logic [1:0] DATA_EXTRA = 2'h2; // further bytes are ignored
	// ==================================================
	// limit format
	localparam logic [15:0] MASK_9BIT = 16'hff80; // resolution 00
	localparam logic [15:0] MASK_10BIT = 16'hffc0; // resolution 01
	localparam logic [15:0] MASK_11BIT = 16'hffe0; // resolution 10
	localparam logic [15:0] MASK_12BIT = 16'hfff0; // resolution 11
	localparam logic [15:0] LIMIT_RESET = 16'h0000; // before nonvolatile reload
	// ==================================================
	// slave states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_PTR = 3'b010,
		ST_DATA = 3'b011,
		ST_ACK = 3'b100,
		ST_READ = 3'b101,
		ST_MACK = 3'b110,
		ST_SKIP = 3'b111
	} tll_state_e;
endpackage

// ---- design/tll_regs.sv ----
// limit registers, lock logic and two-wire slave access
// assumes scl/sda are already synchronous and filtered; nonvolatile copies are inputs
`timescale 1ns/1ps
module tll_regs (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i, // bus clock, sampled
	input wire logic sda_i, // bus data, sampled
	output logic sda_o, // always low when enabled
	output logic sda_oe_o, // high pulls data line low
	input wire logic [2:0] address_select_pins_i,
	input wire logic [15:0] nv_low_limit_i, // nonvolatile copies
	input wire logic [15:0] nv_high_limit_i,
	input wire logic powerup_shutdown_default_i,
	input wire logic reversible_lock_i,
	input wire logic permanent_lockdown_i,
	input wire logic nonvolatile_busy_flag_i,
	input wire logic [1:0] resolution_select_i,
	input wire logic conversion_done_i, // one-cycle pulse per conversion
	output logic shutdown_o,
	output logic regs_locked_o,
	output logic [15:0] cmp_low_limit_o, // limits used by the alarm compare
	output logic [15:0] cmp_high_limit_o,
	output logic fault_count_clear_o, // one-cycle pulse
	output logic [7:0] pointer_o
);
	// ==================================================
	// decode helpers
	// resolution mask, used on write and on read
	function automatic logic [15:0] res_mask(input logic [1:0] res);
		case (res)
			2'b00: res_mask = tll_pkg::MASK_9BIT;
			2'b01: res_mask = tll_pkg::MASK_10BIT;
			2'b10: res_mask = tll_pkg::MASK_11BIT;
			default: res_mask = tll_pkg::MASK_12BIT;
		endcase
	endfunction

	tll_pkg::tll_state_e state; // slave state
	tll_pkg::tll_state_e ret_state; // state after the ack slot
	logic scl_q; // previous clock sample
	logic sda_q; // previous data sample
	logic [3:0] bit_cnt; // bits of the current byte
	logic [7:0] shift; // receive shift register
	logic [7:0] tx_byte; // byte being sent
	logic [1:0] data_idx; // data byte index in a write
	logic [7:0] upper_hold; // upper data byte awaiting the lower
	logic read_lower; // next read byte is the lower one
	logic load_pend; // reload from nonvolatile after reset
	logic lockdown; // sticky permanent lockdown
	logic [15:0] low_limit; // volatile limits
	logic [15:0] high_limit;
	logic upd_pend; // accepted write waiting for a conversion

	// ==================================================
	// edge and condition decode
	wire scl_rise = scl_i & ~scl_q;
	wire scl_fall = ~scl_i & scl_q;
	wire bus_start = scl_i & scl_q & sda_q & ~sda_i;
	wire bus_stop = scl_i & scl_q & ~sda_q & sda_i;
	wire byte_done = scl_fall & (bit_cnt == tll_pkg::BITS_PER_BYTE);
	wire addr_match = (shift[7:1] == {tll_pkg::DEV_ADDR_HI, address_select_pins_i});
	wire locked = reversible_lock_i | lockdown;
	wire [15:0] mask = res_mask(resolution_select_i);
	wire [15:0] wr_value = {upper_hold, shift} & mask;
	wire ptr_low = (pointer_o == tll_pkg::PTR_LOW_LIMIT);
	wire ptr_high = (pointer_o == tll_pkg::PTR_HIGH_LIMIT);
	wire [15:0] rd_reg = ptr_low ? low_limit : (ptr_high ? high_limit : tll_pkg::LIMIT_RESET);
	wire [15:0] rd_value = rd_reg & mask;
	wire lower_done = byte_done & (state == tll_pkg::ST_DATA) & (data_idx == tll_pkg::DATA_LOWER);
	// refused while busy, locked or locked down; lock clearing lives in the config block
	wire wr_accept = lower_done & ~nonvolatile_busy_flag_i & ~locked & (ptr_low | ptr_high);
	wire wr_changes = ptr_low ? (wr_value != low_limit) : (wr_value != high_limit);

	// ==================================================
	// sampled history for edge detection
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// ==================================================
	// slave sequencer; start and stop override every state
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= tll_pkg::ST_IDLE;
			ret_state <= tll_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx_byte <= 8'h00;
			data_idx <= tll_pkg::DATA_UPPER;
			upper_hold <= 8'h00;
			read_lower <= 1'b0;
			sda_oe_o <= 1'b0;
			pointer_o <= 8'h00;
		end else if (bus_start) begin
			// restart drops any half-written limit
			state <= tll_pkg::ST_ADDR;
			bit_cnt <= 4'h0;
			data_idx <= tll_pkg::DATA_UPPER;
			sda_oe_o <= 1'b0;
		end else if (bus_stop) begin
			state <= tll_pkg::ST_IDLE;
			data_idx <= tll_pkg::DATA_UPPER;
			sda_oe_o <= 1'b0;
		end else begin
			case (state)
				tll_pkg::ST_ADDR, tll_pkg::ST_PTR, tll_pkg::ST_DATA: begin
					if (scl_rise) begin
						shift <= {shift[6:0], sda_i};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_done) begin
						state <= tll_pkg::ST_ACK;
						if (state == tll_pkg::ST_ADDR) begin
							// foreign address: stay off the line until stop/start
							sda_oe_o <= addr_match;
							ret_state <= !addr_match ? tll_pkg::ST_SKIP :
								(shift[0] ? tll_pkg::ST_READ : tll_pkg::ST_PTR);
							tx_byte <= rd_value[15:8];
							read_lower <= 1'b1;
						end else if (state == tll_pkg::ST_PTR) begin
							sda_oe_o <= 1'b1;
							pointer_o <= shift;
							ret_state <= tll_pkg::ST_DATA;
						end else begin
							// busy: data bytes are not acknowledged
							sda_oe_o <= ~nonvolatile_busy_flag_i;
							ret_state <= tll_pkg::ST_DATA;
							if (data_idx == tll_pkg::DATA_UPPER) begin
								upper_hold <= shift;
							end
							if (data_idx != tll_pkg::DATA_EXTRA) begin
								data_idx <= data_idx + 2'h1;
							end
						end
					end
				end
				tll_pkg::ST_ACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						state <= ret_state;
						// first read bit goes out as the ack slot ends
						sda_oe_o <= (ret_state == tll_pkg::ST_READ) & ~tx_byte[7];
					end
				end
				tll_pkg::ST_READ: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == tll_pkg::BITS_PER_BYTE) begin
							sda_oe_o <= 1'b0;
							state <= tll_pkg::ST_MACK;
						end else begin
							sda_oe_o <= ~tx_byte[3'h7 - bit_cnt[2:0]];
						end
					end
				end
				tll_pkg::ST_MACK: begin
					if (scl_rise) begin
						// master nack ends the read and leaves the line free
						state <= sda_i ? tll_pkg::ST_SKIP : tll_pkg::ST_ACK;
						ret_state <= tll_pkg::ST_READ;
						tx_byte <= read_lower ? rd_value[7:0] : rd_value[15:8];
						read_lower <= ~read_lower;
					end
				end
				tll_pkg::ST_SKIP: begin
					sda_oe_o <= 1'b0;
				end
				default: begin
					sda_oe_o <= 1'b0;
				end
			endcase
		end
	end

	assign sda_o = 1'b0;
	assign regs_locked_o = locked;

	// ==================================================
	// limits, lockdown and start-up mode
	// reset cannot sample ports, so the reload happens one edge after release
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			load_pend <= 1'b1;
			lockdown <= 1'b0;
			low_limit <= tll_pkg::LIMIT_RESET;
			high_limit <= tll_pkg::LIMIT_RESET;
			shutdown_o <= 1'b0;
			fault_count_clear_o <= 1'b0;
		end else begin
			lockdown <= lockdown | permanent_lockdown_i;
			fault_count_clear_o <= 1'b0;
			if (load_pend) begin
				load_pend <= 1'b0;
				low_limit <= nv_low_limit_i;
				high_limit <= nv_high_limit_i;
				shutdown_o <= powerup_shutdown_default_i;
			end else if (wr_accept) begin
				if (ptr_low) begin
					low_limit <= wr_value;
				end else begin
					high_limit <= wr_value;
				end
				fault_count_clear_o <= wr_changes;
			end
		end
	end

	// ==================================================
	// compare copies, refreshed only at a conversion boundary
	// keeps one conversion from mixing old and new limits
	// upd_pend skips copies when no write was accepted and no reload came since the last copy, so the outputs never toggle needlessly
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			upd_pend <= 1'b1; // first conversion after the reload edge always copies
			cmp_low_limit_o <= tll_pkg::LIMIT_RESET;
			cmp_high_limit_o <= tll_pkg::LIMIT_RESET;
		end else begin
			// a commit in the copy cycle: the copy takes the old value and the flag stays set
			if (conversion_done_i & upd_pend & ~load_pend) begin
				cmp_low_limit_o <= low_limit;
				cmp_high_limit_o <= high_limit;
				upd_pend <= 1'b0;
			end
			if (wr_accept | load_pend) begin
				upd_pend <= 1'b1;
			end
		end
	end

	// ==================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_lower_in;
		lower_done;
	endsequence
	sequence s_no_change;
		$stable(low_limit) && $stable(high_limit);
	endsequence
	// master declines after a read byte
	sequence s_nack_in;
		scl_rise && state == tll_pkg::ST_MACK && sda_i;
	endsequence
	// an address byte has just finished
	sequence s_addr_in;
		byte_done && state == tll_pkg::ST_ADDR;
	endsequence

	chk_locked_no_write: assert property (s_lower_in and locked |=> s_no_change)
		else $error("limit changed while locked");
	chk_lockdown_wins: assert property (s_lower_in and (lockdown && !reversible_lock_i) |=> s_no_change)
		else $error("limit changed under lockdown");
	chk_lockdown_sticky: assert property (lockdown |=> lockdown)
		else $error("lockdown bit returned to zero");
	chk_busy_nack: assert property (byte_done && state == tll_pkg::ST_DATA && nonvolatile_busy_flag_i
		&& !bus_start && !bus_stop |=> !sda_oe_o)
		else $error("data byte acked while busy");
	chk_busy_no_write: assert property (s_lower_in and nonvolatile_busy_flag_i |=> s_no_change)
		else $error("limit changed while busy");
	// a committed value keeps only the bits of the resolution in force at the commit
	chk_limit_masked: assert property (wr_accept && !load_pend
		|=> (($past(ptr_low) ? low_limit : high_limit) & ~$past(mask)) == 16'h0000)
		else $error("limit low bits not zero");
	chk_write_clears: assert property (wr_accept && wr_changes && !load_pend |=> fault_count_clear_o)
		else $error("fault counter not cleared on change");
	// the first edge after release loads, the second shows the nonvolatile values
	chk_reload_nv: assert property ($rose(rst_n_i) |-> load_pend ##1 (low_limit == $past(nv_low_limit_i)
		&& high_limit == $past(nv_high_limit_i) && shutdown_o == $past(powerup_shutdown_default_i)))
		else $error("limits not reloaded after reset");
	chk_cmp_on_conv: assert property (conversion_done_i && !load_pend |=> cmp_high_limit_o == $past(high_limit))
		else $error("compare limit not refreshed");
	chk_cmp_hold: assert property (!conversion_done_i && !load_pend |=> $stable(cmp_low_limit_o))
		else $error("compare limit moved between conversions");

	// ==================================================
	// protocol and side-effect checks
	// the line is answered only for our own address
	chk_addr_ack: assert property (s_addr_in |=> sda_oe_o == $past(addr_match))
		else $error("address ack does not follow match");
	// after a decline the line stays free for stop or restart
	chk_nack_release: assert property (s_nack_in |=> (!sda_oe_o) [*4])
		else $error("data line held after master nack");
	// limits move only at a lower-byte commit or the reload, so partial and extra bytes do nothing
	chk_commit_only: assert property (!lower_done && !load_pend |=> s_no_change)
		else $error("limit changed outside a commit");
	// pointer moves only when a pointer byte completes
	chk_ptr_kept: assert property (!(byte_done && state == tll_pkg::ST_PTR) |=> $stable(pointer_o))
		else $error("pointer changed without pointer byte");
	// fault counter clear follows an accepted write only
	chk_clear_cause: assert property (fault_count_clear_o |-> $past(wr_accept))
		else $error("fault clear without accepted write");
	// start-up mode is fixed once the reload edge has passed
	chk_shutdown_hold: assert property (!load_pend |=> $stable(shutdown_o))
		else $error("shutdown mode changed after reload");
endmodule

// ---- verification/tll_bus_master.sv ----
// two-wire bus master model for the limit register block
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module tll_bus_master (
	input wire logic sys_clk_i,
	input wire logic sda_i, // resolved wire level
	output logic scl_o, // stands high between frames
	output logic sda_o // 1 = released
);
	// ==================================================
	// bus phases, all changes just after a clock edge
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	// data set while clock low, wire sampled mid high phase
	task automatic bit_x(input logic b, output logic r);
		sda_o <= b;
		tick(4);
		scl_o <= 1'b1;
		tick(3);
		r = sda_i;
		tick(3);
		scl_o <= 1'b0;
		tick(2);
	endtask
	// also serves as repeated start from clock low
	task automatic start();
		sda_o <= 1'b1;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b0;
		tick(4);
		scl_o <= 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		tick(2);
		scl_o <= 1'b1;
		tick(4);
		sda_o <= 1'b1;
		tick(4);
	endtask
	// eight bits msb first, then the ack slot driven with ab
	task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r, output logic a);
		logic t; // one sampled bit
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], t);
			r[i] = t;
		end
		bit_x(ab, a);
	endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the limit register block
// assumes the master model owns the bus clock and data wire
`timescale 1ns/1ps
module testbench;
	// ==================================================
	// signals and model state
	logic sys_clk_i, rst_n_i, scl, m_sda, dsda, oe, psd, rlock, plock, busy, cdone, sd, locked, fcc, a1, pl;
	logic [2:0] asel;
	logic [1:0] res;
	logic [15:0] nv_lo, nv_hi, c_lo, c_hi;
	logic [7:0] ptr, r8;
	wire logic sda;
	int n_errors = 0;
	int num_checks = 0;
	int n_fcc = 0; // fault clear pulses seen
	logic [31:0] seed = 32'h0001702e; // xorshift start value 94254
	logic [15:0] lim [2]; // model limits: low, high
	logic [15:0] cmpm [2]; // model compare limits
	assign sda = m_sda & ~(oe & ~dsda); // pull-up, device only pulls low
	tll_regs u_tll_regs (.sys_clk_i, .rst_n_i, .scl_i(scl), .sda_i(sda), .sda_o(dsda), .sda_oe_o(oe),
		.address_select_pins_i(asel), .nv_low_limit_i(nv_lo), .nv_high_limit_i(nv_hi),
		.powerup_shutdown_default_i(psd), .reversible_lock_i(rlock), .permanent_lockdown_i(plock),
		.nonvolatile_busy_flag_i(busy), .resolution_select_i(res), .conversion_done_i(cdone),
		.shutdown_o(sd), .regs_locked_o(locked), .cmp_low_limit_o(c_lo), .cmp_high_limit_o(c_hi),
		.fault_count_clear_o(fcc), .pointer_o(ptr));
	tll_bus_master u_tll_bus_master (.sys_clk_i, .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) if (fcc === 1'b1) n_fcc++;
	// ==================================================
	// helpers
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	function automatic logic [15:0] msk(input logic [1:0] r);
		return 16'hffff << (3'h7 - {1'b0, r});
	endfunction
	// compares values that have stood at least a cycle, so stimulus after it stays on the edge
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic conv();
		chk("cmp low", cmpm[0], c_lo);
		chk("cmp high", cmpm[1], c_hi);
		cdone <= 1'b1;
		@(posedge sys_clk_i);
		cdone <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		cmpm = lim;
		chk("cmp low", cmpm[0], c_lo);
		chk("cmp high", cmpm[1], c_hi);
	endtask
	// n data bytes (third one is surplus), rs adds a repeated start
	task automatic wlim(input logic h, input logic [15:0] v, input int n, input logic rs);
		logic [4:0] ak, e;
		logic [15:0] nv;
		logic [7:0] p, d;
		int f0;
		f0 = n_fcc;
		nv = v & msk(res);
		p = h ? tll_pkg::PTR_HIGH_LIMIT : tll_pkg::PTR_LOW_LIMIT;
		e = 5'h0;
		ak = 5'h1f;
		for (int i = 0; i < 3; i++) e[2-i] = (i >= n) | busy;
		u_tll_bus_master.start();
		u_tll_bus_master.xfer({tll_pkg::DEV_ADDR_HI, asel, 1'b0}, 1'b1, r8, ak[4]);
		u_tll_bus_master.xfer(p, 1'b1, r8, ak[3]);
		for (int i = 0; i < n; i++) begin
			d = i == 0 ? v[15:8] : (i == 1 ? v[7:0] : 8'h5a);
			u_tll_bus_master.xfer(d, 1'b1, r8, ak[2-i]);
		end
		if (rs) u_tll_bus_master.start();
		u_tll_bus_master.stop();
		chk("acks", {11'h0, e}, {11'h0, ak});
		chk("locked", {15'h0, rlock | pl}, {15'h0, locked});
		if (n >= 2 && !busy && !(rlock | pl)) begin
			f0 = f0 + int'(lim[h] != nv);
			lim[h] = nv;
		end
		chk("fault clear", 16'(f0), 16'(n_fcc));
		chk("pointer", {8'h0, p}, {8'h0, ptr});
	endtask
	// two rounds: master acks after the first lower byte
	task automatic rd(input logic [15:0] e);
		logic [7:0] u, l;
		logic a;
		u_tll_bus_master.start();
		u_tll_bus_master.xfer({tll_pkg::DEV_ADDR_HI, asel, 1'b1}, 1'b1, u, a);
		chk("read ack", 16'h0, {15'h0, a});
		for (int k = 0; k < 2; k++) begin
			u_tll_bus_master.xfer(8'hff, 1'b0, u, a);
			u_tll_bus_master.xfer(8'hff, k[0], l, a);
			chk("read data", e, {u, l});
		end
		chk("nack slot", 16'h1, {15'h0, a});
		u_tll_bus_master.stop();
	endtask
	task automatic do_reset(input logic s);
		rst_n_i <= 1'b0;
		psd <= s;
		nv_lo <= (rnd() | 16'h8000) & 16'hff80;
		nv_hi <= rnd() & 16'h7f80;
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		lim[0] = nv_lo;
		lim[1] = nv_hi;
		cmpm = '{16'h0, 16'h0};
		pl = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk("shutdown", {15'h0, s}, {15'h0, sd});
		chk("locked", 16'h0, {15'h0, locked});
		conv();
	endtask
	// ==================================================
	// main sequence
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		n_errors++;
		end_of_test();
	end
	initial begin
		rst_n_i = 1'b0;
		{psd, rlock, plock, busy, cdone} = 5'h0;
		res = 2'h0;
		asel = 3'(rnd());
		nv_lo = 16'h0;
		nv_hi = 16'h0;
		do_reset(1'b1);
		for (int k = 0; k < 4; k++) begin
			res <= 2'(k);
			@(posedge sys_clk_i);
			wlim(1'b0, rnd() | 16'h8000, 3, 1'b0);
			wlim(1'b1, rnd() & 16'h7fff, 3, 1'b0);
			conv();
			rd(lim[1]);
		end
		wlim(1'b1, lim[1], 2, 1'b0);
		wlim(1'b0, rnd() | 16'h8000, 1, 1'b1);
		rd(lim[0]);
		busy <= 1'b1;
		@(posedge sys_clk_i);
		wlim(1'b0, rnd() | 16'h8000, 3, 1'b0);
		busy <= 1'b0;
		rlock <= 1'b1;
		@(posedge sys_clk_i);
		wlim(1'b1, rnd() & 16'h7fff, 3, 1'b0);
		rlock <= 1'b0;
		plock <= 1'b1;
		@(posedge sys_clk_i);
		plock <= 1'b0;
		@(posedge sys_clk_i);
		pl = 1'b1;
		wlim(1'b1, rnd() & 16'h7fff, 3, 1'b0);
		rd(lim[1]);
		u_tll_bus_master.start();
		u_tll_bus_master.xfer({tll_pkg::DEV_ADDR_HI, ~asel, 1'b0}, 1'b1, r8, a1);
		u_tll_bus_master.stop();
		chk("foreign ack", 16'h1, {15'h0, a1});
		conv();
		do_reset(1'b0);
		end_of_test();
	end
endmodule
